/* File: rtl/ten_bit_parallel_port.sv */
// ten-bit general-purpose port: two 4-bit ports, one 2-bit port, byte registers
// assumes stepper phases, timer outputs and the serial RTS command bit come
// from neighbouring blocks on the same clock; pin levels arrive asynchronously
`default_nettype none
module ten_bit_parallel_port
  import pport_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [3:0]        port_zero_pin_i,
  output logic      [3:0]        port_zero_pin_o,
  output logic      [3:0]        port_zero_pin_oe_o,
  input  wire logic [3:0]        port_one_pin_i,
  output logic      [3:0]        port_one_pin_o,
  output logic      [3:0]        port_one_pin_oe_o,
  input  wire logic [1:0]        port_two_pin_i,
  output logic      [1:0]        port_two_pin_o,
  output logic      [1:0]        port_two_pin_oe_o,
  input  wire logic              timer_output_three_i,
  input  wire logic              timer_output_four_i,
  input  wire logic              timer_flipflop_three_i,
  input  wire logic              timer_flipflop_four_i,
  input  wire logic [3:0]        stepper_phase_outputs_zero_i,
  input  wire logic [3:0]        stepper_phase_outputs_one_i,
  output logic      [1:0]        stepper_run_o,
  output logic      [1:0]        stepper_half_step_o,
  output logic      [1:0]        stepper_trigger_o,
  input  wire logic              serial_zero_rts_cmd_i,
  output logic                   serial_zero_clear_to_send_o
);
  logic [7:0] func_q;
  logic [7:0] dir_q;
  logic [7:0] p2ctl_q;
  logic [3:0] p0dat_q;
  logic [3:0] p1dat_q;
  logic [1:0] p2dat_q;
  logic [PINS_W-1:0] level;

  pin_sampler #(
    .W(PINS_W)
  ) u_sampler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  ({port_two_pin_i, port_one_pin_i, port_zero_pin_i}),
    .level_o(level)
  );

  wire [3:0] lvl0 = level[3:0];
  wire [3:0] lvl1 = level[7:4];
  wire [1:0] lvl2 = level[9:8];

  // address decode
  wire hit_func  = (addr_i == OFS_FUNC);
  wire hit_p0dat = (addr_i == OFS_P0DAT);
  wire hit_p1dat = (addr_i == OFS_P1DAT);
  wire hit_dir   = (addr_i == OFS_DIR01);
  wire hit_p2ctl = (addr_i == OFS_P2CTL);
  wire hit_p2dat = (addr_i == OFS_P2DAT);

  wire wr_func  = wr_i && hit_func;
  wire wr_p0dat = wr_i && hit_p0dat;
  wire wr_p1dat = wr_i && hit_p1dat;
  wire wr_dir   = wr_i && hit_dir;
  wire wr_p2ctl = wr_i && hit_p2ctl;
  wire wr_p2dat = wr_i && hit_p2dat;

  // field views
  wire [1:0] fn0   = func_q[FUNC0_LSB +: 2];
  wire [1:0] fn1   = func_q[FUNC1_LSB +: 2];
  wire [3:0] dir0  = dir_q[3:0];
  wire [3:0] dir1  = dir_q[7:4];
  wire       p2sel = p2ctl_q[P2_SEL_BIT];
  wire [1:0] p2dir = {p2ctl_q[P2_DIR1_BIT], p2ctl_q[P2_DIR0_BIT]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      func_q  <= RST_FUNC;
      dir_q   <= RST_DIR01;
      p2ctl_q <= RST_P2CTL;
      p0dat_q <= RST_DATA[3:0];
      p1dat_q <= RST_DATA[3:0];
      p2dat_q <= RST_DATA[1:0];
    end else begin
      if (wr_func) func_q <= wdata_i & FUNC_WR_MASK;
      if (wr_dir) dir_q <= wdata_i;
      if (wr_p2ctl) p2ctl_q <= wdata_i & P2CTL_WR_MASK;
      if (wr_p0dat) p0dat_q <= wdata_i[3:0];
      if (wr_p1dat) p1dat_q <= wdata_i[3:0];
      if (wr_p2dat) p2dat_q <= wdata_i[1:0];
    end
  end

  // pin output selection: function field steers what a driven pin carries
  wire [3:0] p0_alt = fn0[1] ? stepper_phase_outputs_zero_i : p0dat_q;
  wire [3:0] p1_alt = fn1[1] ? stepper_phase_outputs_one_i : p1dat_q;
  wire [3:0] p0_out_d = (fn0 == FN_TIMER) ?
                        {p0dat_q[3:1], timer_output_three_i} : p0_alt;
  wire [3:0] p1_out_d = (fn1 == FN_TIMER) ?
                        {p1dat_q[3:1], timer_output_four_i} : p1_alt;

  // the serial select overrides the per-pin direction: pin zero drives RTS, pin one is input
  wire [1:0] p2_oe_d  = p2sel ? 2'b01 : p2dir;
  // rts pin is active low: command bit set drives a low level
  wire [1:0] p2_out_d = p2sel ? {1'b0, ~serial_zero_rts_cmd_i} : p2dat_q;
  // clear-to-send idles inactive (high) while the pin is plain I/O
  wire       cts_d    = p2sel ? lvl2[1] : 1'b1;

  wire [1:0] run_d  = {fn1[1], fn0[1]};
  wire [1:0] half_d = {fn1 == FN_HALF, fn0 == FN_HALF};
  wire [1:0] trig_d = {timer_flipflop_four_i & run_d[1],
                       timer_flipflop_three_i & run_d[0]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_zero_pin_o    <= 4'h0;
      port_zero_pin_oe_o <= 4'h0;
      port_one_pin_o     <= 4'h0;
      port_one_pin_oe_o  <= 4'h0;
      port_two_pin_o     <= 2'h0;
      port_two_pin_oe_o  <= 2'h0;
      serial_zero_clear_to_send_o <= 1'b1;
      stepper_run_o       <= 2'h0;
      stepper_half_step_o <= 2'h0;
      stepper_trigger_o   <= 2'h0;
    end else begin
      port_zero_pin_o    <= p0_out_d;
      port_zero_pin_oe_o <= dir0;
      port_one_pin_o     <= p1_out_d;
      port_one_pin_oe_o  <= dir1;
      port_two_pin_o     <= p2_out_d;
      port_two_pin_oe_o  <= p2_oe_d;
      serial_zero_clear_to_send_o <= cts_d;
      stepper_run_o       <= run_d;
      stepper_half_step_o <= half_d;
      stepper_trigger_o   <= trig_d;
    end
  end

  // read data: output pins read the latch, input pins the sampled level
  wire [3:0] rd_p0 = (dir0 & p0dat_q) | (~dir0 & lvl0);
  wire [3:0] rd_p1 = (dir1 & p1dat_q) | (~dir1 & lvl1);
  wire [1:0] rd_p2 = (p2dir & p2dat_q) | (~p2dir & lvl2);
  wire [7:0] rd_mux =
      hit_func  ? (func_q | FUNC_RD_ONES) :
      hit_dir   ? dir_q :
      hit_p2ctl ? (p2ctl_q & P2CTL_RD_MASK) :
      hit_p0dat ? {4'h0, rd_p0} :
      hit_p1dat ? {4'h0, rd_p1} :
      hit_p2dat ? {6'h00, rd_p2} : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      // data stand only in the cycle after the read strobe
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // checks
  logic seen_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  AST_DIR_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    !seen_q |-> (dir_q == 8'h00) && (port_zero_pin_oe_o == 4'h0))
    else $error("direction register not clear after reset");

  AST_FUNC_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    !seen_q |-> (func_q == 8'h00) && (stepper_run_o == 2'h0))
    else $error("ports not in plain mode after reset");

  AST_P2_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    !seen_q |-> (p2ctl_q == 8'h00) && (p2dat_q == 2'h0))
    else $error("port two registers not clear after reset");

  AST_P0_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_dir ##1 !wr_dir |-> ##1 port_zero_pin_oe_o == $past(wdata_i[3:0], 2))
    else $error("port zero enables do not follow low nibble");

  AST_P1_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_dir ##1 !wr_dir |-> ##1 port_one_pin_oe_o == $past(wdata_i[7:4], 2))
    else $error("port one enables do not follow high nibble");

  AST_P0_TIMER: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn0 == FN_TIMER) |=> port_zero_pin_o[0] == $past(timer_output_three_i))
    else $error("port zero bit zero does not carry timer output");

  AST_P1_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    fn1[1] |=> port_one_pin_o == $past(stepper_phase_outputs_one_i))
    else $error("port one does not carry stepper phases");

  AST_HALF_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_func && wdata_i[1:0] == FN_HALF) |=> ##1 stepper_half_step_o[0])
    else $error("half-step code not reflected");

  AST_FUNC_ONES: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_func) |=> rdata_o[3] && rdata_o[7])
    else $error("function register bits 3 and 7 not read as one");

  AST_P2_WO: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p2ctl) |=> !rdata_o[1])
    else $error("port two pin one direction read back");

  AST_P2_OVERRIDE: assert property (@(posedge clk_i) disable iff (rst_i)
    p2sel |=> port_two_pin_oe_o == 2'b01)
    else $error("select bit does not override port two directions");

  AST_RTS_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    p2sel |=> port_two_pin_o[0] == !$past(serial_zero_rts_cmd_i))
    else $error("rts pin level not inverse of command bit");

  AST_P2_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    !p2sel |=> port_two_pin_oe_o == $past(p2dir))
    else $error("port two enables do not follow direction bits");

  AST_CTS_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    !p2sel |=> serial_zero_clear_to_send_o)
    else $error("clear-to-send active while port two is plain");

  AST_READ_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p0dat && dir0 == 4'h0) |=> rdata_o[3:0] == $past(lvl0))
    else $error("input pin read does not return sampled level");

  // pin drive per function code; direction stays with the enables
  AST_P0_GPIO: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn0 == FN_GPIO) |=> port_zero_pin_o == $past(p0dat_q))
    else $error("port zero does not drive its data latch");

  AST_P1_GPIO: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn1 == FN_GPIO) |=> port_one_pin_o == $past(p1dat_q))
    else $error("port one does not drive its data latch");

  AST_P0_TIMER_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn0 == FN_TIMER) |=> port_zero_pin_o[3:1] == $past(p0dat_q[3:1]))
    else $error("port zero upper pins lost plain data in timer mode");

  AST_P0_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    fn0[1] |=> port_zero_pin_o == $past(stepper_phase_outputs_zero_i))
    else $error("port zero does not carry stepper phases");

  AST_P0_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    fn0[1] |=> stepper_trigger_o[0] == $past(timer_flipflop_three_i))
    else $error("port zero stepper trigger does not follow its timer");

  AST_P0_NO_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    !fn0[1] |=> !stepper_trigger_o[0] && !stepper_run_o[0])
    else $error("port zero stepper active outside stepper mode");

  AST_P1_TIMER: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn1 == FN_TIMER) |=> port_one_pin_o[0] == $past(timer_output_four_i))
    else $error("port one bit zero does not carry timer output");

  AST_P1_TIMER_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn1 == FN_TIMER) |=> port_one_pin_o[3:1] == $past(p1dat_q[3:1]))
    else $error("port one upper pins lost plain data in timer mode");

  AST_P1_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    fn1[1] |=> stepper_trigger_o[1] == $past(timer_flipflop_four_i))
    else $error("port one stepper trigger does not follow its timer");

  AST_P1_NO_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    !fn1[1] |=> !stepper_trigger_o[1] && !stepper_run_o[1])
    else $error("port one stepper active outside stepper mode");

  AST_FULL_STEP0: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn0 == FN_FULL) |=> stepper_run_o[0] && !stepper_half_step_o[0])
    else $error("port zero full-step code not reflected");

  AST_FULL_STEP1: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn1 == FN_FULL) |=> stepper_run_o[1] && !stepper_half_step_o[1])
    else $error("port one full-step code not reflected");

  AST_HALF_STEP1: assert property (@(posedge clk_i) disable iff (rst_i)
    (fn1 == FN_HALF) |=> stepper_run_o[1] && stepper_half_step_o[1])
    else $error("port one half-step code not reflected");

  // read-back uses $past: the mux is looked at one edge before rdata_o shows it
  AST_FUNC_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_func) |=> rdata_o[2:0] == $past(func_q[2:0]) &&
                           rdata_o[6:4] == $past(func_q[6:4]))
    else $error("function register stored bits not read back");

  AST_DIR_READ0: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_dir) |=> rdata_o[3:0] == $past(dir0))
    else $error("port zero directions not read back");

  AST_DIR_READ1: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_dir) |=> rdata_o[7:4] == $past(dir1))
    else $error("port one directions not read back");

  AST_P0_READ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p0dat) |=> (rdata_o[3:0] & $past(dir0)) == ($past(p0dat_q) & $past(dir0)))
    else $error("port zero output pins do not read the latch");

  AST_P1_READ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p1dat) |=> (rdata_o[3:0] & $past(dir1)) == ($past(p1dat_q) & $past(dir1)))
    else $error("port one output pins do not read the latch");

  AST_P1_READ_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p1dat) |=> (rdata_o[3:0] & ~$past(dir1)) == ($past(lvl1) & ~$past(dir1)))
    else $error("port one input pins do not read the sampled level");

  AST_READ_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && (hit_p0dat || hit_p1dat)) |=> rdata_o[7:4] == 4'h0)
    else $error("four-bit port read sets upper bits");

  // port two and the serial control pins
  AST_P2_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    !p2sel |=> port_two_pin_o == $past(p2dat_q))
    else $error("port two does not drive its data latch");

  AST_P2_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p2dat) |=> (rdata_o[1:0] & $past(p2dir)) == ($past(p2dat_q) & $past(p2dir)))
    else $error("port two output pins do not read the latch");

  AST_P2_READ_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p2dat) |=> (rdata_o[1:0] & ~$past(p2dir)) == ($past(lvl2) & ~$past(p2dir)))
    else $error("port two input pins do not read the sampled level");

  AST_P2_SEL_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit_p2ctl) |=> rdata_o[2] == $past(p2sel))
    else $error("serial select bit not read back");

  AST_CTS_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    p2sel |=> serial_zero_clear_to_send_o == $past(lvl2[1]))
    else $error("clear-to-send does not follow port two pin one");

  AST_P2_OE_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    !seen_q |-> (port_two_pin_oe_o == 2'h0) && (port_two_pin_o == 2'h0))
    else $error("port two pins not plain inputs after reset");

  AST_P2_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_p2ctl |=> p2ctl_q[2:0] == $past(wdata_i[2:0]))
    else $error("write-only direction bit not stored");
endmodule
`default_nettype wire

/* File: rtl/pport_pkg.sv */
// constants of the ten-bit parallel port: offsets, field positions, resets
// assumes a byte-wide register port addressed at the printed byte offsets
// Functional notes
// - port zero directions from low nibble
// - port one directions from high nibble
// - direction register resets to all inputs
// - ports zero and one reset to plain I/O
// - port zero field picks I/O, timer, stepper
// - port one field picks I/O, timer, stepper
// - codes 10/11 select full or half step
// - function register resets zero, bits 3,7 read one
// - each port two pin own direction bit
// - port two pin one direction is write-only
// - select bit routes RTS and CTS to port two
// - select bit overrides port two directions
// - port two data and control reset zero
// - RTS command bit set drives pin low
`default_nettype none
package pport_pkg;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PINS_W = 10;

  localparam logic [9:0] OFS_FUNC  = 10'h331;
  localparam logic [9:0] OFS_P0DAT = 10'h333;
  localparam logic [9:0] OFS_P1DAT = 10'h335;
  localparam logic [9:0] OFS_DIR01 = 10'h337;
  localparam logic [9:0] OFS_P2CTL = 10'h339;
  localparam logic [9:0] OFS_P2DAT = 10'h33b;

  localparam logic [7:0] RST_FUNC  = 8'h00;
  localparam logic [7:0] RST_DIR01 = 8'h00;
  localparam logic [7:0] RST_P2CTL = 8'h00;
  localparam logic [7:0] RST_DATA  = 8'h00;
  localparam logic [7:0] FUNC_RD_ONES = 8'h88;

  localparam int unsigned FUNC0_LSB = 0;
  localparam int unsigned FUNC1_LSB = 4;
  localparam int unsigned P2_DIR0_BIT = 0;
  localparam int unsigned P2_DIR1_BIT = 1;
  localparam int unsigned P2_SEL_BIT  = 2;
  localparam logic [7:0] FUNC_WR_MASK  = 8'h77;
  localparam logic [7:0] P2CTL_WR_MASK = 8'h07;
  localparam logic [7:0] P2CTL_RD_MASK = 8'h05;

  localparam logic [1:0] FN_GPIO  = 2'b00;
  localparam logic [1:0] FN_TIMER = 2'b01;
  localparam logic [1:0] FN_FULL  = 2'b10;
  localparam logic [1:0] FN_HALF  = 2'b11;
endpackage
`default_nettype wire

/* File: rtl/pin_sampler.sv */
// three-stage sampler for asynchronous pin levels
// a new level is accepted only once the second and third stages agree
`default_nettype none
module pin_sampler #(
  parameter int unsigned W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_q[g]    <= 1'b0;
          s2_q[g]    <= 1'b0;
          s3_q[g]    <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // a one-cycle disagreement keeps the previous level
          if (s2_q[g] == s3_q[g]) begin
            level_o[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: test/pin_board.sv */
// board model on the far side of the ten general-purpose pins
// assumes the bench supplies the level the board would drive on undriven pins
`default_nettype none
module pin_board (
  input  wire logic [9:0] oe_i,
  input  wire logic [9:0] drive_i,
  input  wire logic [9:0] board_i,
  output logic      [9:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a pin driven by the port shows its drive, any other pin the board level
  assign level_o = (oe_i & drive_i) | (~oe_i & board_i);
endmodule
`default_nettype wire

/* File: test/ten_bit_parallel_port_bench.sv */
// self-checking bench of the ten-bit parallel port
// assumes pport_pkg and the pin_board model are compiled first
`default_nettype none
module ten_bit_parallel_port_bench import pport_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wr_i, rd_i, t3, t4, f3, f4, rts, cts;
  logic [9:0] addr_i, ext;
  wire  [9:0] lvl, oe, drv;
  logic [7:0] exp_q[$];
  logic [7:0] wdata_i, rdata_o, d0, d1, dr;
  logic [3:0] ph0, ph1;
  logic [1:0] run, half, trig;
  int failures, comparisons, cycles;
  ten_bit_parallel_port ten_bit_parallel_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .port_zero_pin_i(lvl[3:0]),
    .port_zero_pin_o(drv[3:0]), .port_zero_pin_oe_o(oe[3:0]),
    .port_one_pin_i(lvl[7:4]), .port_one_pin_o(drv[7:4]), .port_one_pin_oe_o(oe[7:4]),
    .port_two_pin_i(lvl[9:8]), .port_two_pin_o(drv[9:8]), .port_two_pin_oe_o(oe[9:8]),
    .timer_output_three_i(t3), .timer_output_four_i(t4), .timer_flipflop_three_i(f3),
    .timer_flipflop_four_i(f4), .stepper_phase_outputs_zero_i(ph0),
    .stepper_phase_outputs_one_i(ph1), .stepper_run_o(run), .stepper_half_step_o(half),
    .stepper_trigger_o(trig), .serial_zero_rts_cmd_i(rts),
    .serial_zero_clear_to_send_o(cts));
  pin_board pin_board_inst (.oe_i(oe), .drive_i(drv), .board_i(ext), .level_o(lvl));
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(exp);
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(what, exp_q.pop_front(), rdata_o);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // model of one four-pin port's drive value for a function code
  function automatic logic [3:0] pexp(int fn, logic [3:0] d, logic t, logic [3:0] ph);
    if (fn == 0) return d;
    if (fn == 1) return {d[3:1], t};
    return ph;
  endfunction
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i, t3, t4, f3, f4, rts, ph0, ph1} = '0;
    rst_i = 1'b1;
    ext = 10'h000;
    void'($urandom(32'h4263));
    for (int pass = 0; pass < 2; pass++) begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_FUNC, 8'h88, "function reset");
      rd(OFS_DIR01, 8'h00, "direction reset");
      rd(OFS_P2CTL, 8'h00, "port two control reset");
      chk("enables after reset", 8'h00, oe[7:0]);
      chk("port two enables after reset", 8'h00, {6'h00, oe[9:8]});
      rd(10'h000, 8'h00, "unmapped read");
      rd(OFS_P0DAT, {4'h0, ext[3:0]}, "port zero inputs");
      for (int i = 0; i < 3; i++) begin
        dr = 8'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        @(posedge clk_i);
        ext <= 10'($urandom);
        wr(OFS_DIR01, dr);
        wr(OFS_P0DAT, d0);
        wr(OFS_P1DAT, d1);
        settle(8);
        chk("direction enables", dr, oe[7:0]);
        rd(OFS_DIR01, dr, "direction readback");
        rd(OFS_P0DAT, {4'h0, (d0[3:0] & dr[3:0]) | (ext[3:0] & ~dr[3:0])}, "port zero");
        rd(OFS_P1DAT, {4'h0, (d1[3:0] & dr[7:4]) | (ext[7:4] & ~dr[7:4])}, "port one");
      end
      wr(OFS_DIR01, 8'hff);
      for (int fn = 0; fn < 4; fn++) begin
        @(posedge clk_i);
        {t3, t4, f3, f4} <= 4'($urandom);
        ph0 <= 4'($urandom);
        ph1 <= 4'($urandom);
        wr(OFS_FUNC, {2'b00, fn[1:0], 2'b00, fn[1:0]});
        settle(2);
        chk("port zero drive", {4'h0, pexp(fn, d0[3:0], t3, ph0)}, {4'h0, drv[3:0]});
        chk("port one drive", {4'h0, pexp(fn, d1[3:0], t4, ph1)}, {4'h0, drv[7:4]});
        chk("stepper run", {6'h00, {2{fn[1]}}}, {6'h00, run});
        chk("half step", {6'h00, {2{fn == 3}}}, {6'h00, half});
        chk("trigger", {6'h00, {f4, f3} & {2{fn[1]}}}, {6'h00, trig});
        rd(OFS_FUNC, 8'h88 | {2'b00, fn[1:0], 2'b00, fn[1:0]}, "function readback");
      end
      for (int c = 0; c < 4; c++) begin
        d0 = 8'($urandom);
        @(posedge clk_i);
        ext <= 10'($urandom);
        wr(OFS_P2CTL, c[7:0]);
        wr(OFS_P2DAT, d0);
        settle(8);
        chk("port two enables", {6'h00, c[1:0]}, {6'h00, oe[9:8]});
        chk("port two drive", {6'h00, d0[1:0] & c[1:0]}, {6'h00, drv[9:8] & oe[9:8]});
        rd(OFS_P2CTL, {6'h00, 1'b0, c[0]}, "port two control");
        rd(OFS_P2DAT, {6'h00, (d0[1:0] & c[1:0]) | (ext[9:8] & ~c[1:0])}, "port two");
        chk("clear to send idle", 8'h01, {7'h00, cts});
      end
      for (int r = 0; r < 2; r++) begin
        @(posedge clk_i);
        rts <= r[0];
        ext <= 10'($urandom);
        wr(OFS_P2CTL, 8'h07);
        settle(8);
        chk("serial enables", 8'h01, {6'h00, oe[9:8]});
        chk("request to send pin", {7'h00, ~r[0]}, {7'h00, drv[8]});
        chk("clear to send", {7'h00, ext[9]}, {7'h00, cts});
        rd(OFS_P2CTL, 8'h05, "serial control");
      end
      @(posedge clk_i);
      rst_i <= 1'b1;
    end
    end_sim();
  end
endmodule
`default_nettype wire
